// *** rtl/sram_wb_regs.vh ***
/*
 static ram controller constants: array size, access sizes, reset values.
 assumes inclusion by bare name from the design files.
*/
`ifndef SRAM_WB_REGS_VH
`define SRAM_WB_REGS_VH
`define SRAM_BYTES 16384
`define SRAM_AW 12
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define LANES_NONE 4'h0
`define LANES_ALL 4'hf
`define LANES_HALF 4'h3
`define LANES_BYTE 4'h1
`define WORD_ZERO 32'h0000_0000
`define BYTE_ZERO 8'h00
`define ADDR_ZERO 12'h000
`endif

// *** rtl/sram_array.v ***
/*
 word-wide static ram array built from flip-flops with byte-lane write enables.
 assumes writes are issued only by the controller on the same clock.
*/
`timescale 1ns/1ps
`include "sram_wb_regs.vh"
module sram_array #(
  parameter AW = `SRAM_AW
) (
  // clock
  input wire mclk_i,
  // write port
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [3:0] wr_lane_i,
  input wire [31:0] wr_data_i,
  // read port
  input wire [AW-1:0] rd_addr_i,
  output wire [31:0] rd_data_o
);
  reg [31:0] mem [0:(1<<AW)-1];
  genvar b;
  // no reset on the array: contents survive a warm reset
  generate
    for (b = 0; b < 4; b = b + 1) begin : lane
      always @(posedge mclk_i) begin
        if (wr_en_i && wr_lane_i[b]) begin
          mem[wr_addr_i][8*b+7:8*b] <= wr_data_i[8*b+7:8*b];
        end
      end
    end
  endgenerate
  assign rd_data_o = mem[rd_addr_i];
endmodule

// *** rtl/sram_writeback_buffer_ctrl.v ***
/*
 static ram controller with a single-entry write-back buffer.
 assumes a processor on the same clock issuing one request per cycle.
*/
// Overview of operation
// R1 - presents a 16 kB ram usable for code and data
// R2 - byte, halfword and word reads and writes; writes touch only their lanes
// R3 - every write lands in a one-entry buffer, never stalls
// R4 - buffered write goes to the array only when the next write arrives
// R5 - reset discards any pending buffered write
// R6 - software writes twice to make a value survive reset
// R7 - software issues a dummy write before idle or power-down
// R8 - reads hitting the pending entry see buffered bytes merged by lane
`timescale 1ns/1ps
`include "sram_wb_regs.vh"
module sram_writeback_buffer_ctrl #(
  parameter AW = `SRAM_AW
) (
  // clock and reset
  input wire mclk_i,
  input wire resetn_i,
  // processor request
  input wire req_i,
  input wire we_i,
  input wire [AW+1:0] addr_i,
  input wire [1:0] size_i,
  input wire [31:0] wdata_i,
  // processor answer
  output reg ack_o,
  output reg [31:0] rdata_o,
  output reg pend_o
);

  // request decode
  wire wr_req;
  wire rd_req;
  wire [AW-1:0] word_addr;
  wire [1:0] byte_sel;
  wire half_sel;

  // lane enables and replicated write data of the request
  reg [3:0] lane;
  reg [31:0] wlane_data;

  // the single pending entry
  reg pend;
  reg [AW-1:0] pend_addr;
  reg [3:0] pend_lane;
  wire [31:0] pend_data;

  // next values of the pending entry
  reg next_pend;
  reg [AW-1:0] next_pend_addr;
  reg [3:0] next_pend_lane;
  wire [3:0] load_lane;

  // next values of the answer
  reg next_ack;
  reg [31:0] next_rdata;

  // array port and read merge
  wire commit;
  wire hit;
  wire [3:0] hit_lane;
  wire [31:0] arr_data;
  wire [31:0] merged;
  genvar g;

  assign wr_req = req_i && we_i;
  assign rd_req = req_i && !we_i;
  assign word_addr = addr_i[AW+1:2];
  assign byte_sel = addr_i[1:0];
  assign half_sel = addr_i[1];

  // lane enables; size 3 is undefined and acts as a word
  always @* begin
    case (size_i)
      `SIZE_BYTE: begin
        lane = `LANES_BYTE << byte_sel; // R2
      end
      `SIZE_HALF: begin
        lane = `LANES_HALF << {half_sel, 1'b0}; // R2
      end
      `SIZE_WORD: begin
        lane = `LANES_ALL; // R2
      end
      default: begin
        lane = `LANES_ALL;
      end
    endcase
  end

  // narrow data sits in the low bits; replicating it saves a lane shifter
  always @* begin
    case (size_i)
      `SIZE_BYTE: begin
        wlane_data = {4{wdata_i[7:0]}}; // R2
      end
      `SIZE_HALF: begin
        wlane_data = {2{wdata_i[15:0]}}; // R2
      end
      default: begin
        wlane_data = wdata_i;
      end
    endcase
  end

  // old entry reaches the array only when a new write pushes it out
  assign commit = wr_req && pend; // R4

  sram_array #(
    .AW(AW)
  ) u_array ( // R1
    .mclk_i(mclk_i),
    .wr_en_i(commit),
    .wr_addr_i(pend_addr),
    .wr_lane_i(pend_lane),
    .wr_data_i(pend_data),
    .rd_addr_i(word_addr),
    .rd_data_o(arr_data)
  );

  // a read of the pending word must see the buffered bytes
  assign hit = pend && (pend_addr == word_addr); // R8

  generate
    for (g = 0; g < 4; g = g + 1) begin : merge_lane
      assign hit_lane[g] = hit && pend_lane[g];
      assign merged[8*g+7:8*g] = hit_lane[g] ?
        pend_data[8*g+7:8*g] : arr_data[8*g+7:8*g]; // R8
    end
  endgenerate

  always @* begin
    next_pend = pend;
    next_pend_addr = pend_addr;
    next_pend_lane = pend_lane;
    if (wr_req) begin
      next_pend = 1'b1; // R3
      next_pend_addr = word_addr;
      next_pend_lane = lane;
    end
  end

  // bytes outside the lane mask may go stale; the mask hides them
  assign load_lane = wr_req ? lane : `LANES_NONE;

  generate
    for (g = 0; g < 4; g = g + 1) begin : pend_byte
      reg [7:0] data;
      always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          data <= `BYTE_ZERO;
        end else if (load_lane[g]) begin
          data <= wlane_data[8*g+7:8*g]; // R3
        end
      end
      assign pend_data[8*g+7:8*g] = data;
    end
  endgenerate

  always @* begin
    next_ack = req_i; // R3
    next_rdata = rdata_o;
    if (rd_req) begin
      next_rdata = merged; // R8
    end
  end

  // the array has no reset, so only the last write is lost
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend <= 1'b0; // R5
      pend_addr <= `ADDR_ZERO;
      pend_lane <= `LANES_NONE;
    end else begin
      pend <= next_pend;
      pend_addr <= next_pend_addr;
      pend_lane <= next_pend_lane;
    end
  end

  // one cycle answer, never a stall
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= next_ack; // R3
    end
  end

  // read data holds until the next read
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `WORD_ZERO;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // copy of the pending flag for the outside world
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_o <= 1'b0; // R5
    end else begin
      pend_o <= next_pend;
    end
  end

endmodule

// *** bench/cpu_model.sv ***
/* core model; assumes tb calls acc right after a clock edge */
`timescale 1ns/1ps
module cpu_model(input wire mclk_i,output reg req_i=0,output reg we_i=0,
output reg [13:0] addr_i=0,output reg [1:0] size_i=0,
output reg [31:0] wdata_i=0);
task acc(input w,input [13:0] a,input [1:0] s,input [31:0] d);
req_i<=1;we_i<=w;addr_i<=a;size_i<=s;wdata_i<=d;
@(posedge mclk_i);
endtask
// idle data inverted so stale values never pass
task idle;
req_i<=0;wdata_i<=~wdata_i;
endtask
endmodule

// *** bench/sram_wb_monitor.sv ***
/* checker on controller ports; assumes bind below */
`timescale 1ns/1ps
module sram_wb_monitor(input wire mclk_i,input wire resetn_i,
input wire req_i,input wire we_i,input wire ack_o,input wire pend_o);
default clocking @(posedge mclk_i); endclocking
default disable iff (!resetn_i);
sequence s_write; req_i&&we_i; endsequence
sequence s_wr_done; ack_o&&pend_o; endsequence
property p_ack; req_i|=>ack_o; endproperty
a_ack: assert property(p_ack) else $error("ack late");
property p_idle; !req_i|=>!ack_o; endproperty
a_idle: assert property(p_idle) else $error("stray ack");
property p_pend; s_write|=>s_wr_done; endproperty
a_pend: assert property(p_pend) else $error("no pending");
property p_hold; pend_o|=>pend_o; endproperty
a_hold: assert property(p_hold) else $error("pending lost");
property p_quiet; !pend_o&&!(req_i&&we_i)|=>!pend_o; endproperty
a_quiet: assert property(p_quiet) else $error("stray pending");
property p_rd; req_i&&!we_i|=>pend_o==$past(pend_o); endproperty
a_rd: assert property(p_rd) else $error("read moved pending");
property p_rst; $rose(resetn_i)|->!pend_o&&!ack_o; endproperty
a_rst: assert property(p_rst) else $error("reset kept pending");
endmodule
bind sram_writeback_buffer_ctrl sram_wb_monitor u_mon(.*);

// *** bench/tb.sv ***
/* bench: byte model checks every read; assumes one clock */
`timescale 1ns/1ps
module tb;
reg mclk_i=0,resetn_i=0;
wire req_i,we_i,ack_o,pend_o;
wire [13:0] addr_i;
wire [1:0] size_i;
wire [31:0] wdata_i,rdata_o;
integer miscompares=0,checks=0,seed=31,k,i,n;
reg [7:0] mem[int],prev[int];
reg [31:0] e;
initial forever #2 mclk_i=~mclk_i;
cpu_model u_cpu(.*);
sram_writeback_buffer_ctrl u_dut(.*);
task tally_and_finish;
if(miscompares==0&&checks>0) $display("Test passed");
else $display("Test failed");
$finish;
endtask
task wr(input [13:0] b,input [1:0] s,input [31:0] d);
n=s==0?1:s==1?2:4;
b=b/n*n;
prev=mem;
for(i=0;i<n;i++) mem[b+i]=d[8*i+:8];
u_cpu.acc(1,b,s,d);
endtask
task rd(input [13:0] b);
for(i=0;i<4;i++) e[8*i+:8]=mem[b/4*4+i];
u_cpu.acc(0,b,2,0);
u_cpu.idle;
@(negedge mclk_i);
checks+=2;
if(rdata_o!==e) begin
miscompares++;
$display("Error rdata exp %h got %h",e,rdata_o);
end
if(ack_o!==1'b1) begin
miscompares++;
$display("Error ack_o exp 1 got %b",ack_o);
end
@(posedge mclk_i);
endtask
// reset drops the pending write, so the model falls back one write
task rst;
u_cpu.idle;
@(negedge mclk_i) resetn_i<=0;
@(negedge mclk_i) resetn_i<=1;
checks++;
if(pend_o!==1'b0) begin
miscompares++;
$display("Error pend_o exp 0 got %b",pend_o);
end
mem=prev;
@(posedge mclk_i);
endtask
initial begin
repeat(8) @(posedge mclk_i);
resetn_i<=1;
@(posedge mclk_i);
for(k=0;k<16;k++) wr(k*4,2,$random(seed));
wr(14'h3ffc,2,$random(seed));
rd(14'h3ffc);
for(k=0;k<40;k++) begin
wr($random(seed)&63,$random(seed),$random(seed));
rd(addr_i);
end
wr(14'h0040,2,32'h1111_1111);
wr(14'h0040,2,32'h2222_2222);
rst;
rd(14'h0040);
wr(14'h0044,2,32'h3333_3333);
wr(14'h0044,2,32'h3333_3333);
rst;
rd(14'h0044);
wr(14'h0048,2,32'h4444_4444);
wr(14'h004c,2,32'h0000_0000);
rst;
rd(14'h0048);
tally_and_finish;
end
initial begin
#9000;
miscompares++;
tally_and_finish;
end
endmodule
